//--- logic/aer_pkg.sv
package aer_pkg;
	// ===========================================================
	// Register byte offsets
	localparam logic [11:0] AER_OFF_CORR_STATUS = 12'h0110;
	localparam logic [11:0] AER_OFF_CORR_MASK = 12'h0114;
	localparam logic [11:0] AER_OFF_ERR_CTL = 12'h0118;
	localparam logic [11:0] AER_OFF_HDR_LOG0 = 12'h011c;
	localparam logic [11:0] AER_OFF_HDR_LOG1 = 12'h0120;
	localparam logic [11:0] AER_OFF_HDR_LOG2 = 12'h0124;
	localparam logic [11:0] AER_OFF_HDR_LOG3 = 12'h0128;
	localparam logic [11:0] AER_OFF_SER_HDR = 12'h0180;
	localparam logic [11:0] AER_OFF_SER_LO = 12'h0184;
	localparam logic [11:0] AER_OFF_SER_HI = 12'h0188;
	localparam logic [11:0] AER_OFF_VC_HDR = 12'h0200;
	localparam logic [11:0] AER_OFF_VC_CAP1 = 12'h0204;
	localparam logic [11:0] AER_OFF_LOCK = 12'h0300;
	localparam logic [11:0] AER_OFF_IRQ_MASK = 12'h0304;
	// ===========================================================
	// Field layouts and reset values
	localparam logic [31:0] AER_CORR_IMPL = 32'h0000_31c1;
	localparam logic [31:0] AER_CORR_MASK_RST = 32'h0000_2000;
	localparam int AER_FEP_MSB = 4;
	localparam int AER_GEN_CAP_BIT = 5;
	localparam int AER_GEN_EN_BIT = 6;
	localparam int AER_CHK_CAP_BIT = 7;
	localparam int AER_CHK_EN_BIT = 8;
	localparam logic [15:0] AER_SER_CAP_ID = 16'h0003;
	localparam logic [15:0] AER_VC_CAP_ID = 16'h0002;
	localparam logic [3:0] AER_CAP_VER = 4'h1;
	localparam logic [11:0] AER_NEXT_RST = 12'h000;
	localparam logic [2:0] AER_EXTRA_VC = 3'h0;
	localparam logic [31:0] AER_UNMAPPED = 32'h0000_0000;
endpackage

//--- logic/aer_regs.sv
// Notes on behaviour
// - Set mask bit suppresses correctable event reporting
// - Masks sticky RW, zero reset, advisory resets one
// - Read-only sticky first error index field
// - Gen/check capable bits default one, lockable
// - Generation enable bit drives ECRC append
// - Check enable bit drives ECRC verification
// - Four header words logged on first error
// - Serial header reads ID 3, version 1
// - Serial number two lockable sticky halves
// - VC header reads ID 2, version 1
// - VC next link defaults zero, lockable
// - Extra channel count reads zero
// - Status bits set by event, write-one clear
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module aer_regs
	import aer_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic hot_rst_n,
	input wire logic clk_en,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic receiver_fault,
	input wire logic corrupt_packet,
	input wire logic corrupt_link_packet,
	input wire logic replay_number_wrap,
	input wire logic replay_timer_expiry,
	input wire logic advisory_nonfatal,
	input wire logic uncorr_event,
	input wire logic [4:0] uncorr_index,
	input wire logic [127:0] uncorr_header,
	output logic corr_report,
	output logic e2e_crc_gen_enable,
	output logic e2e_crc_check_enable,
	output logic irq
);
	// ===========================================================
	// Bus decode
	logic [31:0] corr_status_r;
	logic [31:0] corr_mask_r;
	logic [4:0] first_error_index_r;
	logic log_valid_r;
	logic gen_cap_r, chk_cap_r, gen_en_r, chk_en_r;
	logic [31:0] hdr_log_r [4];
	logic [11:0] ser_next_r, vc_next_r;
	logic [31:0] ser_lo_r, ser_hi_r;
	logic lock_r;
	logic [31:0] irq_mask_r;
	logic ack_r;
	logic [31:0] rdata_nxt;
	logic [31:0] wmask;
	logic [31:0] corr_evt;
	logic wr, rd;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	// One wait cycle per access while clk_en is high, answered on the second edge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wr = avs_write & ack_r & clk_en;
	assign rd = avs_read & ~ack_r & clk_en;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ack_r <= 1'b0;
		end else if (clk_en) begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
		end
	end

	// ===========================================================
	// Correctable status and mask
	assign corr_evt = {18'h0_0000, advisory_nonfatal, replay_timer_expiry,
		3'h0, replay_number_wrap, corrupt_link_packet, corrupt_packet,
		5'h00, receiver_fault};

	// Sticky: only the power-on reset clears it; set beats clear
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			corr_status_r <= 32'h0000_0000;
		end else if (clk_en) begin
			corr_status_r <= ((corr_status_r & ~((wr &&
				hit(avs_address, AER_OFF_CORR_STATUS)) ?
				(avs_writedata & wmask) : 32'h0000_0000)) | corr_evt)
				& AER_CORR_IMPL;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			corr_mask_r <= AER_CORR_MASK_RST;
		end else if (clk_en && wr && hit(avs_address, AER_OFF_CORR_MASK)) begin
			corr_mask_r <= merge(corr_mask_r, avs_writedata, wmask)
				& AER_CORR_IMPL;
		end
	end

	// Masked events still log status but never report
	assign corr_report = |(corr_evt & ~corr_mask_r);

	// ===========================================================
	// Error control and header log
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gen_en_r <= 1'b0;
			chk_en_r <= 1'b0;
		end else if (clk_en && wr && hit(avs_address, AER_OFF_ERR_CTL)
			&& avs_byteenable[AER_CHK_EN_BIT / 8] ) begin
			gen_en_r <= avs_writedata[AER_GEN_EN_BIT];
			chk_en_r <= avs_writedata[AER_CHK_EN_BIT];
		end
	end

	// Capability bits live with the hot-reset domain
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gen_cap_r <= 1'b1;
			chk_cap_r <= 1'b1;
		end else if (clk_en) begin
			if (!hot_rst_n) begin
				gen_cap_r <= 1'b1;
				chk_cap_r <= 1'b1;
			end else if (wr && !lock_r && avs_byteenable[0]
				&& hit(avs_address, AER_OFF_ERR_CTL)) begin
				gen_cap_r <= avs_writedata[AER_GEN_CAP_BIT];
				chk_cap_r <= avs_writedata[AER_CHK_CAP_BIT];
			end
		end
	end

	assign e2e_crc_gen_enable = gen_en_r;
	assign e2e_crc_check_enable = chk_en_r;

	// First error only; log rearms once software writes all ones to the pointer field
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			log_valid_r <= 1'b0;
			first_error_index_r <= 5'h00;
			for (int i = 0; i < 4; i++) begin
				hdr_log_r[i] <= 32'h0000_0000;
			end
		end else if (clk_en) begin
			if (uncorr_event && !log_valid_r) begin
				log_valid_r <= 1'b1;
				first_error_index_r <= uncorr_index;
				for (int i = 0; i < 4; i++) begin
					hdr_log_r[i] <= uncorr_header[32*i +: 32];
				end
			end else if (wr && hit(avs_address, AER_OFF_ERR_CTL)
				&& avs_byteenable[0] && avs_writedata[AER_FEP_MSB:0] == 5'h1f) begin
				log_valid_r <= 1'b0;
			end
		end
	end

	// ===========================================================
	// Serial number and VC headers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ser_lo_r <= 32'h0000_0000;
			ser_hi_r <= 32'h0000_0000;
		end else if (clk_en && wr && !lock_r) begin
			if (hit(avs_address, AER_OFF_SER_LO)) begin
				ser_lo_r <= merge(ser_lo_r, avs_writedata, wmask);
			end
			if (hit(avs_address, AER_OFF_SER_HI)) begin
				ser_hi_r <= merge(ser_hi_r, avs_writedata, wmask);
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ser_next_r <= AER_NEXT_RST;
			vc_next_r <= AER_NEXT_RST;
		end else if (clk_en) begin
			if (!hot_rst_n) begin
				ser_next_r <= AER_NEXT_RST;
				vc_next_r <= AER_NEXT_RST;
			end else if (wr && !lock_r && avs_byteenable[3]) begin
				if (hit(avs_address, AER_OFF_SER_HDR)) begin
					ser_next_r <= avs_writedata[31:20];
				end
				if (hit(avs_address, AER_OFF_VC_HDR)) begin
					vc_next_r <= avs_writedata[31:20];
				end
			end
		end
	end

	// ===========================================================
	// Lock and interrupt
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lock_r <= 1'b0;
			irq_mask_r <= 32'h0000_0000;
		end else if (clk_en && wr && avs_byteenable[0]) begin
			if (hit(avs_address, AER_OFF_LOCK)) begin
				lock_r <= avs_writedata[0];
			end
			if (hit(avs_address, AER_OFF_IRQ_MASK)) begin
				irq_mask_r <= merge(irq_mask_r, avs_writedata, wmask)
					& AER_CORR_IMPL;
			end
		end
	end

	// Interrupt follows status only; mask register chooses sources
	assign irq = |(corr_status_r & irq_mask_r);

	// ===========================================================
	// Read mux
	always_comb begin
		rdata_nxt = AER_UNMAPPED;
		unique case (avs_address)
			AER_OFF_CORR_STATUS: rdata_nxt = corr_status_r;
			AER_OFF_CORR_MASK: rdata_nxt = corr_mask_r;
			AER_OFF_ERR_CTL: rdata_nxt = {23'h00_0000, chk_en_r, chk_cap_r,
				gen_en_r, gen_cap_r, first_error_index_r};
			AER_OFF_HDR_LOG0: rdata_nxt = hdr_log_r[0];
			AER_OFF_HDR_LOG1: rdata_nxt = hdr_log_r[1];
			AER_OFF_HDR_LOG2: rdata_nxt = hdr_log_r[2];
			AER_OFF_HDR_LOG3: rdata_nxt = hdr_log_r[3];
			AER_OFF_SER_HDR: rdata_nxt = {ser_next_r, AER_CAP_VER,
				AER_SER_CAP_ID};
			AER_OFF_SER_LO: rdata_nxt = ser_lo_r;
			AER_OFF_SER_HI: rdata_nxt = ser_hi_r;
			AER_OFF_VC_HDR: rdata_nxt = {vc_next_r, AER_CAP_VER,
				AER_VC_CAP_ID};
			AER_OFF_VC_CAP1: rdata_nxt = {29'h0000_0000,
				AER_EXTRA_VC};
			AER_OFF_LOCK: rdata_nxt = {31'h0000_0000, lock_r};
			AER_OFF_IRQ_MASK: rdata_nxt = irq_mask_r;
			default: rdata_nxt = AER_UNMAPPED;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd) begin
			avs_readdata <= rdata_nxt;
		end
	end

	// ===========================================================
	// Checks
	sequence s_event_unmasked;
		receiver_fault && !corr_mask_r[0];
	endsequence

	sequence s_bus_req;
		clk_en && (avs_read || avs_write) && !ack_r;
	endsequence

	sequence s_ctl_write;
		wr && hit(avs_address, AER_OFF_ERR_CTL) && avs_byteenable[1];
	endsequence

	sequence s_hot_reset;
		clk_en && !hot_rst_n;
	endsequence

	AST_MASK_SUPPRESS: assert property (@(posedge mclk) disable iff (!arst_n)
		!(|(corr_evt & ~corr_mask_r)) |-> !corr_report)
		else $error("masked event reported");
	AST_UNMASKED_REPORT: assert property (@(posedge mclk) disable iff (!arst_n)
		s_event_unmasked |-> corr_report)
		else $error("unmasked event not reported");
	AST_STATUS_SET: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && receiver_fault |=> corr_status_r[0])
		else $error("status bit not set");
	AST_STATUS_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
		corr_status_r[0] && !wr |=> corr_status_r[0])
		else $error("status bit lost");
	AST_FIRST_ONLY: assert property (@(posedge mclk) disable iff (!arst_n)
		log_valid_r && uncorr_event |=> $stable(first_error_index_r))
		else $error("first error index overwritten");
	AST_LOG_CAPTURE: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && uncorr_event && !log_valid_r
		|=> hdr_log_r[3] == $past(uncorr_header[127:96]))
		else $error("header log word wrong");
	AST_LOCK_SERIAL: assert property (@(posedge mclk) disable iff (!arst_n)
		lock_r |=> $stable(ser_lo_r) && $stable(ser_hi_r))
		else $error("serial changed while locked");
	AST_VC_ID: assert property (@(posedge mclk) disable iff (!arst_n)
		rd && avs_address == AER_OFF_VC_HDR
		|=> avs_readdata[19:0] == 20'h1_0002)
		else $error("vc header id wrong");
	AST_GEN_OUT: assert property (@(posedge mclk) disable iff (!arst_n)
		e2e_crc_gen_enable == avs_readdata[AER_GEN_EN_BIT] || !$past(rd)
		|| $past(avs_address) != AER_OFF_ERR_CTL)
		else $error("generation enable mismatch");

	// ===========================================================
	// Handshake and freeze checks
	// Exactly one stall cycle while clk_en is high, so masters can rely on the timing
	AST_WAIT_FIRST: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_bus_req |-> avs_waitrequest)
		else $error("request not stalled");
	AST_ONE_WAIT: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_bus_req |=> !avs_waitrequest)
		else $error("extra wait state");
	AST_READ_STANDS: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!rd |=> $stable(avs_readdata))
		else $error("read data moved without a read");
	AST_FREEZE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!clk_en |=> $stable(corr_status_r) && $stable(corr_mask_r)
		&& $stable(lock_r))
		else $error("state moved while frozen");

	// ===========================================================
	// Field checks
	AST_MASK_WRITE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		wr && hit(avs_address, AER_OFF_CORR_MASK) && (&avs_byteenable)
		|=> corr_mask_r == ($past(avs_writedata) & AER_CORR_IMPL))
		else $error("mask write wrong");
	AST_ADV_MASKED: assert property (
		@(posedge mclk) disable iff (!arst_n)
		advisory_nonfatal && corr_mask_r[13]
		&& !(|(corr_evt[12:0] & ~corr_mask_r[12:0])) |-> !corr_report)
		else $error("masked advisory reported");
	AST_GEN_WRITE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_ctl_write
		|=> e2e_crc_gen_enable == $past(avs_writedata[AER_GEN_EN_BIT]))
		else $error("generation enable not written");
	AST_CHK_WRITE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_ctl_write
		|=> e2e_crc_check_enable == $past(avs_writedata[AER_CHK_EN_BIT]))
		else $error("check enable not written");
	AST_FEP_HOLD: assert property (
		@(posedge mclk) disable iff (!arst_n)
		!(clk_en && uncorr_event) |=> $stable(first_error_index_r))
		else $error("first error index moved");
	AST_LOG_WORD0: assert property (
		@(posedge mclk) disable iff (!arst_n)
		clk_en && uncorr_event && !log_valid_r
		|=> hdr_log_r[0] == $past(uncorr_header[31:0]))
		else $error("header log first word wrong");
	// Hot reset restores only the non-sticky fields
	AST_CAP_HOT: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_hot_reset |=> gen_cap_r && chk_cap_r)
		else $error("capable bits not restored");
	AST_NEXT_HOT: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_hot_reset
		|=> ser_next_r == AER_NEXT_RST && vc_next_r == AER_NEXT_RST)
		else $error("next links not restored");
	AST_STICKY_HOT: assert property (
		@(posedge mclk) disable iff (!arst_n)
		s_hot_reset ##0 !wr
		|=> $stable(ser_lo_r) && $stable(corr_mask_r) && $stable(gen_en_r))
		else $error("sticky field lost on hot reset");
	AST_LOCK_LINKS: assert property (
		@(posedge mclk) disable iff (!arst_n)
		lock_r && hot_rst_n
		|=> $stable(gen_cap_r) && $stable(chk_cap_r)
		&& $stable(ser_next_r) && $stable(vc_next_r))
		else $error("lockable field changed while locked");
	AST_SER_WRITE: assert property (
		@(posedge mclk) disable iff (!arst_n)
		wr && !lock_r && hit(avs_address, AER_OFF_SER_LO)
		&& (&avs_byteenable) |=> ser_lo_r == $past(avs_writedata))
		else $error("serial low word not written");
	AST_SER_ID: assert property (
		@(posedge mclk) disable iff (!arst_n)
		rd && avs_address == AER_OFF_SER_HDR
		|=> avs_readdata[19:0] == 20'h1_0003)
		else $error("serial header id wrong");
	AST_EVC_ZERO: assert property (
		@(posedge mclk) disable iff (!arst_n)
		rd && avs_address == AER_OFF_VC_CAP1
		|=> avs_readdata[2:0] == 3'h0)
		else $error("extra channel count not zero");
endmodule
`default_nettype wire

//--- tb/aer_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aer_regs_tb;
	import aer_pkg::*;
	// ===========================================================
	// Bench signals
	typedef struct packed {
		logic we;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] m;
		logic [31:0] e;
	} aer_row_t;
	logic mclk, arst_n, hot_rst_n, clk_en, avs_read, avs_write;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic avs_waitrequest, uncorr_event, corr_report, gen_en, chk_en, irq;
	logic [5:0] ev;
	logic [4:0] uncorr_index;
	logic [127:0] uncorr_header, hdr;
	int err_total, num_checks;
	aer_row_t rows [22];

	aer_regs uut (.mclk(mclk), .arst_n(arst_n), .hot_rst_n(hot_rst_n),
		.clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .receiver_fault(ev[0]),
		.corrupt_packet(ev[1]), .corrupt_link_packet(ev[2]),
		.replay_number_wrap(ev[3]), .replay_timer_expiry(ev[4]),
		.advisory_nonfatal(ev[5]), .uncorr_event(uncorr_event),
		.uncorr_index(uncorr_index), .uncorr_header(uncorr_header),
		.corr_report(corr_report), .e2e_crc_gen_enable(gen_en),
		.e2e_crc_check_enable(chk_en), .irq(irq));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ===========================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Waitrequest sampled on the rising edge; data taken there too
	task automatic bus(input logic we, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= we;
		avs_read <= !we;
		avs_writedata <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) err_total++;
		rd = avs_readdata;
		chk(32'(n), 32'h0000_0002);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask

	task automatic pulse(input int i, input logic exp);
		@(posedge mclk);
		ev <= 6'(1 << i);
		@(negedge mclk);
		chk({31'h0, corr_report}, {31'h0, exp});
		@(posedge mclk);
		ev <= 6'h00;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ===========================================================
	// Stimulus
	initial begin
		#100000;
		err_total++;
		results();
	end

	initial begin
		{arst_n, avs_read, avs_write, uncorr_event, ev} = '0;
		{hot_rst_n, clk_en, avs_byteenable} = 6'h3f;
		{avs_address, avs_writedata, uncorr_index, uncorr_header} = '0;
		hdr = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
		rows = '{'{0, 12'h114, 0, '1, 32'h0000_2000},
			'{0, 12'h118, 0, '1, 32'h0000_00a0},
			'{0, 12'h11c, 0, '1, 0}, '{0, 12'h120, 0, '1, 0},
			'{0, 12'h124, 0, '1, 0}, '{0, 12'h128, 0, '1, 0},
			'{0, 12'h180, 0, '1, 32'h0001_0003},
			'{0, 12'h184, 0, '1, 0}, '{0, 12'h188, 0, '1, 0},
			'{0, 12'h200, 0, '1, 32'h0001_0002},
			'{0, 12'h204, 0, 32'h0000_0007, 0},
			'{0, 12'h3f0, 0, '1, 0}, '{1, 12'h300, 0, 0, 0},
			'{1, 12'h114, '1, 0, 0}, '{0, 12'h114, 0, '1, 32'h0000_31c1},
			'{1, 12'h118, 32'h0000_0140, 0, 0},
			'{0, 12'h118, 0, '1, 32'h0000_0140},
			'{1, 12'h184, 32'h1234_5678, 0, 0},
			'{0, 12'h184, 0, '1, 32'h1234_5678},
			'{1, 12'h180, 32'habc0_0000, 0, 0},
			'{0, 12'h180, 0, '1, 32'habc1_0003}, '{1, 12'h3f0, '1, 0, 0}};
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			bus(rows[i].we, rows[i].a, rows[i].d);
			if (!rows[i].we) chk(rd & rows[i].m, rows[i].e);
		end
		chk({30'h0, gen_en, chk_en}, 32'h0000_0003);
		$display("register table done");
		// Hot reset keeps sticky state, restores capable bits and links
		@(posedge mclk);
		hot_rst_n <= 1'b0;
		@(posedge mclk);
		hot_rst_n <= 1'b1;
		rdchk(12'h118, 32'h0000_01e0);
		rdchk(12'h184, 32'h1234_5678);
		rdchk(12'h180, 32'h0001_0003);
		bus(1'b1, 12'h200, 32'h0010_0000);
		rdchk(12'h200, 32'h0011_0002);
		$display("hot reset done");
		bus(1'b1, 12'h300, 32'h0000_0001);
		bus(1'b1, 12'h184, 32'h0000_0000);
		rdchk(12'h184, 32'h1234_5678);
		bus(1'b1, 12'h118, 32'h0000_0000);
		rdchk(12'h118, 32'h0000_00a0);
		chk({30'h0, gen_en, chk_en}, 32'h0000_0000);
		bus(1'b1, 12'h300, 32'h0000_0000);
		$display("lock done");
		bus(1'b1, 12'h114, 32'h0000_0000);
		bus(1'b1, 12'h304, 32'h0000_0000);
		for (int i = 0; i < 6; i++) pulse(i, 1'b1);
		rdchk(12'h110, 32'h0000_31c1);
		chk({31'h0, irq}, 32'h0000_0000);
		bus(1'b1, 12'h304, 32'h0000_0040);
		@(negedge mclk);
		chk({31'h0, irq}, 32'h0000_0001);
		bus(1'b1, 12'h110, 32'h0000_0040);
		@(negedge mclk);
		chk({31'h0, irq}, 32'h0000_0000);
		rdchk(12'h110, 32'h0000_3181);
		bus(1'b1, 12'h114, 32'hffff_ffff);
		for (int i = 0; i < 6; i++) pulse(i, 1'b0);
		$display("events done");
		// Frozen clock enable must drop the event
		bus(1'b1, 12'h110, 32'hffff_ffff);
		@(posedge mclk);
		clk_en <= 1'b0;
		ev <= 6'h01;
		@(posedge mclk);
		ev <= 6'h00;
		@(posedge mclk);
		clk_en <= 1'b1;
		rdchk(12'h110, 32'h0000_0000);
		$display("clock enable done");
		// Second error must not overwrite the first log
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			uncorr_event <= 1'b1;
			uncorr_index <= k ? 5'h03 : 5'h0c;
			uncorr_header <= k ? ~hdr : hdr;
			@(posedge mclk);
			uncorr_event <= 1'b0;
		end
		rdchk(12'h118, 32'h0000_00ac);
		for (int k = 0; k < 4; k++) rdchk(12'(12'h11c + 4 * k), hdr[32*k +: 32]);
		$display("header log done");
		@(posedge mclk);
		arst_n <= 1'b0;
		@(posedge mclk);
		arst_n <= 1'b1;
		rdchk(12'h11c, 32'h0000_0000);
		rdchk(12'h184, 32'h0000_0000);
		rdchk(12'h114, 32'h0000_2000);
		rdchk(12'h118, 32'h0000_00a0);
		$display("power reset done");
		results();
	end
endmodule
`default_nettype wire
